// file: design/bcct_defs.svh
// Pin map constants and reset values for the board continuity chain test block.
`ifndef BCCT_DEFS_SVH
`define BCCT_DEFS_SVH

`define BCCT_PIN_COUNT 100
`define BCCT_PIN_MSB 99

// Bit index of a pin is its pin number minus one.
`define BCCT_IDX_SERIAL1_TRANSMIT 84
`define BCCT_IDX_HOST_RESET 25
`define BCCT_IDX_FRAME 23
`define BCCT_IDX_DATA0 19

// Supply, reference and ground pins never take part in the chain.
`define BCCT_IDX_VCC_A 52
`define BCCT_IDX_VCC_B 64
`define BCCT_IDX_VCC_C 92
`define BCCT_IDX_STANDBY_SUPPLY 17
`define BCCT_IDX_VREF 43
`define BCCT_IDX_VSS_A 6
`define BCCT_IDX_VSS_B 30
`define BCCT_IDX_VSS_C 59
`define BCCT_IDX_VSS_D 75
`define BCCT_IDX_ANALOG_GROUND 39

// The host reset filter starts high so power-on is not taken as a release edge.
`define BCCT_SYNC_RESET_VAL 100'h0_0000_0000_0000_0000_0200_0000
`define BCCT_PIN_ZERO 100'h0

`endif

// file: design/bcct_pkg.sv
// Types and pin classification for the board continuity chain test block.
`include "bcct_defs.svh"

package bcct_pkg;

	typedef enum logic [0:0] {
		BCCT_MODE_NORMAL = 1'h0,
		BCCT_MODE_TEST = 1'h1
	} bcct_mode_type;

	typedef logic [`BCCT_PIN_MSB:0] bcct_pins_type;

	// Pins that feed the chain: everything but supplies, references, grounds, the output and host reset.
	function automatic bcct_pins_type bcct_chain_mask();
		bcct_pins_type m;
		m = '1;
		m[`BCCT_IDX_VCC_A] = 1'b0;
		m[`BCCT_IDX_VCC_B] = 1'b0;
		m[`BCCT_IDX_VCC_C] = 1'b0;
		m[`BCCT_IDX_STANDBY_SUPPLY] = 1'b0;
		m[`BCCT_IDX_VREF] = 1'b0;
		m[`BCCT_IDX_VSS_A] = 1'b0;
		m[`BCCT_IDX_VSS_B] = 1'b0;
		m[`BCCT_IDX_VSS_C] = 1'b0;
		m[`BCCT_IDX_VSS_D] = 1'b0;
		m[`BCCT_IDX_ANALOG_GROUND] = 1'b0;
		m[`BCCT_IDX_SERIAL1_TRANSMIT] = 1'b0;
		m[`BCCT_IDX_HOST_RESET] = 1'b0;
		return m;
	endfunction : bcct_chain_mask

endpackage : bcct_pkg

// file: design/bcct_chain_if.sv
// Carrier between the top level and the parity reduction of the chain.
`timescale 1ns/1ps

interface bcct_chain_if;
	import bcct_pkg::*;
	bcct_pins_type bits;
	logic parity;
	modport feed (output bits, input parity);
	modport reduce (input bits, output parity);
endinterface : bcct_chain_if

// file: design/bcct_pin_sync.sv
// Three-stage pin synchroniser with a two-stage agreement filter.
`timescale 1ns/1ps
`include "bcct_defs.svh"

module bcct_pin_sync
	import bcct_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic reset_in,
	input wire bcct_pins_type async_in,
	output bcct_pins_type level_out
);

	bcct_pins_type stage1_r;
	bcct_pins_type stage2_r;
	bcct_pins_type stage3_r;
	bcct_pins_type level_r;

	// Stage one feeds stage two only, so metastability never reaches logic.
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			stage1_r <= `BCCT_SYNC_RESET_VAL;
			stage2_r <= `BCCT_SYNC_RESET_VAL;
			stage3_r <= `BCCT_SYNC_RESET_VAL;
		end else begin
			stage1_r <= async_in;
			stage2_r <= stage1_r;
			stage3_r <= stage2_r;
		end
	end

	// A bit moves only when stages two and three agree, masking a one-cycle glitch.
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			level_r <= `BCCT_SYNC_RESET_VAL;
		end else begin
			level_r <= (stage3_r & ~(stage2_r ^ stage3_r)) | (level_r & (stage2_r ^ stage3_r));
		end
	end

	assign level_out = level_r;

endmodule : bcct_pin_sync

// file: design/bcct_parity.sv
// Combinational odd-parity reduction of the chain inputs.
`timescale 1ns/1ps
`include "bcct_defs.svh"

module bcct_parity
	import bcct_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic reset_in,
	bcct_chain_if.reduce chain
);

	// A plain XOR tree: all low gives low, and any single flip flips the result.
	// It stays combinational; the pad register in the top level absorbs its ripple.
	assign chain.parity = ^chain.bits; // [R18] [R2] [R13] [R14]

	chk_single_flip_toggles: assert property ( // [R2]
		@(posedge clk_sys_in) disable iff (reset_in)
		$countones(chain.bits ^ $past(chain.bits)) == 1 |-> chain.parity != $past(chain.parity))
		else $error("Chain output did not toggle on a single input change.");

	chk_all_low_reads_low: assert property ( // [R12]
		@(posedge clk_sys_in) disable iff (reset_in)
		chain.bits == `BCCT_PIN_ZERO |-> !chain.parity)
		else $error("Chain output not low with all inputs low.");

endmodule : bcct_parity

// file: design/bcct_top.sv
// Board continuity chain test mode for the host-interface pins 1 to 100.
// Contract
// R1: A parity chain covers host-interface pins 1 to 100, apart from the monitor chain.
// R2: In test mode, flipping any one chain input toggles the chain output.
// R3: In test mode normal functions disconnect; all pins are inputs except the output.
// R4: Host reset release with frame and data bit 0 low enters test mode.
// R5: Host reset release with frame or data bit 0 high leaves test mode.
// R6: The host reset pin is not a chain input.
// R7: The chain output drives the first serial transmit pin.
// R8: Chain inputs exclude supplies, references, grounds, the output and host reset.
// R9: In test mode the frame and data bit 0 pins are ordinary chain inputs.
// R10: Supply power-on reset clears test mode.
// R11: Outside test mode chain inputs do not affect the serial transmit pin.
// R12: Just after entry with all inputs low the output is low.
// R13: Raising inputs in descending order alternates the output, ending low.
// R14: Lowering inputs in ascending order alternates the output, ending low.
// R15: The tester drives the input pins and watches the chain output.
// R16: The tester holds every non-supply pin low before power-up.
// R17: The mode flag loads only at host reset release and clears on power-on reset.
// R18: The chain output is the odd parity of all chain inputs.
`timescale 1ns/1ps
`include "bcct_defs.svh"

module bcct_top
	import bcct_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic reset_in,
	input wire bcct_pins_type pin_level_in,
	input wire bcct_pins_type func_drive_in,
	input wire bcct_pins_type func_oe_in,
	output bcct_pins_type pin_drive_out,
	output bcct_pins_type pin_oe_out,
	output bcct_pins_type core_level_out,
	output logic serial1_transmit_out,
	output logic test_mode_out
);

	bcct_pins_type pin_sync;
	bcct_mode_type mode_r;
	logic host_reset_pin_n_prev_r;
	logic host_reset_pin_n;
	logic host_reset_release;
	logic entry_frame;
	logic entry_data0;
	bcct_pins_type drive_r;
	bcct_pins_type oe_r;
	bcct_pins_type core_r;
	bcct_pins_type txd_only;

	bcct_chain_if chain_bus ();

	bcct_pin_sync u_sync (
		.clk_sys_in(clk_sys_in),
		.reset_in(reset_in),
		.async_in(pin_level_in),
		.level_out(pin_sync)
	);

	// The mask leaves host reset out, so it keeps control of the mode. In test
	// mode the frame and data bit 0 pins stay in the mask as plain inputs.
	assign chain_bus.bits = pin_sync & bcct_chain_mask(); // [R1] [R8] [R6] [R9]

	bcct_parity u_parity (
		.clk_sys_in(clk_sys_in),
		.reset_in(reset_in),
		.chain(chain_bus.reduce)
	);

	assign host_reset_pin_n = pin_sync[`BCCT_IDX_HOST_RESET];
	assign entry_frame = pin_sync[`BCCT_IDX_FRAME];
	assign entry_data0 = pin_sync[`BCCT_IDX_DATA0];
	assign host_reset_release = host_reset_pin_n & ~host_reset_pin_n_prev_r;

	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			host_reset_pin_n_prev_r <= 1'b1;
		end else begin
			host_reset_pin_n_prev_r <= host_reset_pin_n;
		end
	end

	// The mode changes only on a host reset release; power-on reset forces normal.
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			mode_r <= BCCT_MODE_NORMAL; // [R10] [R17]
		end else if (host_reset_release) begin
			if (!entry_frame && !entry_data0) begin
				mode_r <= BCCT_MODE_TEST; // [R4]
			end else begin
				mode_r <= BCCT_MODE_NORMAL; // [R5]
			end
		end
	end

	always_comb begin
		txd_only = `BCCT_PIN_ZERO;
		txd_only[`BCCT_IDX_SERIAL1_TRANSMIT] = 1'b1;
	end

	// Pad drive is registered so the pins never see a mux glitch.
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			drive_r <= `BCCT_PIN_ZERO;
			oe_r <= `BCCT_PIN_ZERO;
		end else if (mode_r == BCCT_MODE_TEST) begin
			drive_r <= chain_bus.parity ? txd_only : `BCCT_PIN_ZERO; // [R7]
			oe_r <= txd_only; // [R3]
		end else begin
			drive_r <= func_drive_in; // [R11]
			oe_r <= func_oe_in;
		end
	end

	// The core sees quiet pins in test mode so no function reacts to the tester.
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			core_r <= `BCCT_PIN_ZERO;
		end else if (mode_r == BCCT_MODE_TEST) begin
			core_r <= `BCCT_PIN_ZERO; // [R3]
		end else begin
			core_r <= pin_sync;
		end
	end

	assign pin_drive_out = drive_r;
	assign pin_oe_out = oe_r;
	assign core_level_out = core_r;
	assign serial1_transmit_out = drive_r[`BCCT_IDX_SERIAL1_TRANSMIT];
	assign test_mode_out = (mode_r == BCCT_MODE_TEST);

	chk_entry_on_release: assert property ( // [R4]
		@(posedge clk_sys_in) disable iff (reset_in)
		host_reset_release && !entry_frame && !entry_data0 |=> mode_r == BCCT_MODE_TEST)
		else $error("Test mode not entered on release with entry pins low.");

	chk_exit_on_release: assert property ( // [R5]
		@(posedge clk_sys_in) disable iff (reset_in)
		host_reset_release && (entry_frame || entry_data0) |=> mode_r == BCCT_MODE_NORMAL)
		else $error("Test mode not left on release with an entry pin high.");

	chk_mode_only_on_release: assert property ( // [R17]
		@(posedge clk_sys_in) disable iff (reset_in)
		!host_reset_release |=> $stable(mode_r))
		else $error("Mode changed without a host reset release.");

	chk_por_clears_mode: assert property ( // [R10]
		@(posedge clk_sys_in) disable iff (reset_in)
		$fell(reset_in) |-> mode_r == BCCT_MODE_NORMAL)
		else $error("Mode not normal after power-on reset.");

	chk_only_txd_drives: assert property ( // [R3]
		@(posedge clk_sys_in) disable iff (reset_in)
		mode_r == BCCT_MODE_TEST |=> pin_oe_out == txd_only && core_level_out == `BCCT_PIN_ZERO)
		else $error("Pins not released or core not isolated in test mode.");

	chk_txd_carries_parity: assert property ( // [R7]
		@(posedge clk_sys_in) disable iff (reset_in)
		mode_r == BCCT_MODE_TEST |=> serial1_transmit_out == $past(chain_bus.parity))
		else $error("Serial transmit pin does not carry the chain output.");

	chk_normal_txd_func: assert property ( // [R11]
		@(posedge clk_sys_in) disable iff (reset_in)
		mode_r == BCCT_MODE_NORMAL |=>
			serial1_transmit_out == $past(func_drive_in[`BCCT_IDX_SERIAL1_TRANSMIT]))
		else $error("Chain inputs reached the serial transmit pin outside test mode.");

	chk_reset_pin_excluded: assert property ( // [R6]
		@(posedge clk_sys_in) disable iff (reset_in)
		$changed(host_reset_pin_n) && $stable(chain_bus.bits) |=> $stable(chain_bus.parity))
		else $error("Host reset pin changed the chain output.");

endmodule : bcct_top

// file: verif/bcct_tester.sv
// Board test hardware model that drives the host-interface pins.
`timescale 1ns/1ps
`include "bcct_defs.svh"

module bcct_tester
	import bcct_pkg::*;
(
	input wire logic clk_sys_in,
	output bcct_pins_type pin_level_out
);
	// Every pin starts low so the chain begins from a known state.
	initial pin_level_out = 100'h0;

	// Each step is held for eight cycles so the synchroniser and parity have settled.
	task automatic set_pin(input int idx, input logic val);
		@(negedge clk_sys_in);
		pin_level_out[idx] = val;
		repeat (8) @(negedge clk_sys_in);
	endtask : set_pin

	// Entry pins are set well before the host reset release and held after it.
	task automatic release_host(input logic frame, input logic data0);
		@(negedge clk_sys_in);
		pin_level_out[`BCCT_IDX_HOST_RESET] = 1'b0;
		pin_level_out[`BCCT_IDX_FRAME] = frame;
		pin_level_out[`BCCT_IDX_DATA0] = data0;
		repeat (6) @(negedge clk_sys_in);
		pin_level_out[`BCCT_IDX_HOST_RESET] = 1'b1;
		repeat (14) @(negedge clk_sys_in);
	endtask : release_host
endmodule : bcct_tester

// file: verif/tb.sv
// Self-checking testbench for the board continuity chain test block.
`timescale 1ns/1ps
`include "bcct_defs.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
	$display("Error %s expected %h seen %h", nm, e, g); end end

module tb
	import bcct_pkg::*;
;
	localparam bcct_pins_type ONLY_TX = 100'h0001_0000_0000_0000_0000_0000_0;
	logic clk_sys_in = 1'b0;
	logic reset_in = 1'b1;
	bcct_pins_type pins;
	bcct_pins_type func_drive = ONLY_TX;
	bcct_pins_type func_oe = 100'h5555_5555_5555_5555_5555_5555_5;
	bcct_pins_type pin_drive;
	bcct_pins_type pin_oe;
	bcct_pins_type core_level;
	logic serial;
	logic test_mode;
	logic exp_par = 1'b0;
	int n_errors = 0;
	int n_checks = 0;
	int cycles = 0;

	initial begin
		forever #5 clk_sys_in = ~clk_sys_in;
	end

	bcct_tester tester (.clk_sys_in(clk_sys_in), .pin_level_out(pins));

	bcct_top uut (
		.clk_sys_in(clk_sys_in),
		.reset_in(reset_in),
		.pin_level_in(pins),
		.func_drive_in(func_drive),
		.func_oe_in(func_oe),
		.pin_drive_out(pin_drive),
		.pin_oe_out(pin_oe),
		.core_level_out(core_level),
		.serial1_transmit_out(serial),
		.test_mode_out(test_mode)
	);

	// Supplies, grounds, the chain output and host reset stay out of the chain.
	function automatic logic in_chain(input int i);
		return !(i inside {6, 17, 25, 30, 39, 43, 52, 59, 64, 75, 84, 92});
	endfunction : in_chain

	task automatic end_sim;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_sim

	// The whole run needs about 1900 cycles; the ceiling leaves ample margin.
	always @(posedge clk_sys_in) begin
		cycles++;
		if (cycles == 6000) begin
			n_errors++;
			end_sim();
		end
	end

	task automatic step_pin(input int i, input logic val);
		tester.set_pin(i, val);
		exp_par ^= in_chain(i);
		`CHK("chain output", exp_par, serial)
		`CHK("test pad drive", (exp_par ? ONLY_TX : 100'h0), pin_drive)
	endtask : step_pin

	task automatic test_power_up;
		repeat (5) @(negedge clk_sys_in);
		`CHK("mode in reset", 1'b0, test_mode)
		reset_in = 1'b0;
		repeat (6) @(negedge clk_sys_in);
		`CHK("normal enables", func_oe, pin_oe)
		`CHK("mode after power up", 1'b0, test_mode)
		$display("test power_up done");
	endtask : test_power_up

	task automatic test_enter;
		tester.release_host(1'b0, 1'b0);
		`CHK("mode entered", 1'b1, test_mode)
		`CHK("test enables", ONLY_TX, pin_oe)
		`CHK("core levels", 100'h0, core_level)
		`CHK("initial output", 1'b0, serial)
		$display("test enter done");
	endtask : test_enter

	task automatic test_raise;
		for (int i = `BCCT_PIN_MSB; i >= 0; i--) begin
			if (i != `BCCT_IDX_HOST_RESET) begin
				step_pin(i, 1'b1);
			end
		end
		`CHK("all high output", 1'b0, serial)
		`CHK("transmit pad", serial, pin_drive[`BCCT_IDX_SERIAL1_TRANSMIT])
		`CHK("core isolated", 100'h0, core_level)
		$display("test raise done");
	endtask : test_raise

	task automatic test_lower;
		for (int i = 0; i <= `BCCT_PIN_MSB; i++) begin
			if (i != `BCCT_IDX_HOST_RESET) begin
				step_pin(i, 1'b0);
			end
		end
		`CHK("all low output", 1'b0, serial)
		$display("test lower done");
	endtask : test_lower

	task automatic test_exit;
		tester.release_host(1'b1, 1'b0);
		`CHK("mode left by frame", 1'b0, test_mode)
		`CHK("enables restored", func_oe, pin_oe)
		tester.set_pin(0, 1'b1);
		`CHK("transmit unchanged", 1'b1, serial)
		`CHK("normal pad drive", func_drive, pin_drive)
		`CHK("core level", 1'b1, core_level[0])
		$display("test exit done");
	endtask : test_exit

	task automatic test_por;
		tester.release_host(1'b0, 1'b0);
		`CHK("mode reentered", 1'b1, test_mode)
		tester.release_host(1'b0, 1'b1);
		`CHK("mode left by data", 1'b0, test_mode)
		tester.release_host(1'b0, 1'b0);
		`CHK("mode before reset", 1'b1, test_mode)
		reset_in = 1'b1;
		@(negedge clk_sys_in);
		`CHK("mode cleared by reset", 1'b0, test_mode)
		reset_in = 1'b0;
		repeat (6) @(negedge clk_sys_in);
		`CHK("mode after reset", 1'b0, test_mode)
		$display("test por done");
	endtask : test_por

	initial begin
		test_power_up();
		test_enter();
		test_raise();
		test_lower();
		test_exit();
		test_por();
		end_sim();
	end
endmodule : tb
